// ### eidl_pkg.sv
// shared constants for the identification loader
package eidl_pkg;
    localparam logic [6:0] EIDL_SLAVE_ADDR = 7'h50;
    localparam logic EIDL_RD_BIT = 1'b1;
    localparam logic EIDL_WR_BIT = 1'b0;
    localparam logic [7:0] EIDL_START_WORD = 8'h00;
    localparam int EIDL_CLK_MHZ = 100;
    localparam int EIDL_SCL_KHZ = 100;
    localparam int EIDL_QTR_CYC = (EIDL_CLK_MHZ * 1000) / (EIDL_SCL_KHZ * 4);
    localparam int EIDL_NBYTES = 10;
    // arbitrary neutral defaults, not any maker's codes
    localparam logic [15:0] EIDL_DEF_VENDOR = 16'h1234;
    localparam logic [15:0] EIDL_DEF_DEVICE = 16'h5678;
    localparam logic [15:0] EIDL_DEF_SSVEN = 16'h9ABC;
    localparam logic [15:0] EIDL_DEF_SSDEV = 16'hDEF0;
    localparam int EIDL_POS_VENDOR = 0;
    localparam int EIDL_POS_DEVICE = 16;
    localparam int EIDL_POS_SSVEN = 32;
    localparam int EIDL_POS_SSDEV = 48;
endpackage

// ### eidl_sync.sv
// two-stage synchroniser for one pin level
`timescale 1ns/1ps
module eidl_sync (
    input wire logic clock,
    input wire logic resetn,
    input wire logic pinIn,
    output logic pinSync
);
    logic stage1_r;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            // low until the pin is seen, a held bus never looks free
            stage1_r <= 1'b0;
            pinSync <= 1'b0;
        end else begin
            stage1_r <= pinIn;
            pinSync <= stage1_r;
        end
    end
endmodule

// ### eidl_loader.sv
// two-wire master that loads identification bytes after reset
`timescale 1ns/1ps
// Notes on behaviour
// - the loader reads vendor, product and configuration bytes from eeprom.
// - both lines are only pulled low or released, pull-ups give the high.
// - a start is data falling while clock is high.
// - a stop is data rising while clock is high.
// - once a start has been sent, data changes only while clock is low, except at the repeated start and the stop.
// - a transfer begins only when both lines are seen high.
// - every transfer opens with a start and closes with a stop.
// - the receiver acknowledges each byte but the last read byte by data low on the ninth pulse.
// - the eeprom is selected with seven-bit address 1010000b.
// - no page addressing; select bits stay zero.
// - with no eeprom, built-in default identifiers are loaded.
module eidl_loader
    import eidl_pkg::*;
#(
    parameter int NBYTES = EIDL_NBYTES,
    parameter int QTR = EIDL_QTR_CYC
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic [15:0] vendorIdent,
    output logic [15:0] deviceIdent,
    output logic [15:0] subsys_vendor_ident,
    output logic [15:0] subsys_device_ident,
    output logic [8*NBYTES-1:64] configBits,
    output logic loadDone,
    output logic eepromFound
);
    typedef enum {IDLE, START, SEND, RACK, REPSTART, READ, MACK, STOP,
        FINISH} eidl_state_e;
    ////////////////////////////////////////////////////////////////
    logic sclS;
    logic sdaS;
    eidl_sync uSyncScl (.clock(clock), .resetn(resetn), .pinIn(sclIn),
        .pinSync(sclS));
    eidl_sync uSyncSda (.clock(clock), .resetn(resetn), .pinIn(sdaIn),
        .pinSync(sdaS));
    ////////////////////////////////////////////////////////////////
    eidl_state_e state_r;
    eidl_state_e retState_r;
    logic [15:0] tick_r;
    logic [1:0] phase_r;
    logic [3:0] bit_r;
    logic [7:0] shift_r;
    logic [1:0] step_r;
    logic [7:0] count_r;
    logic [8*NBYTES-1:0] image_r;
    logic sdaLow_r;
    logic sclLow_r;
    logic ackBad_r;
    wire tickEnd = (tick_r == 16'(QTR - 1));
    // bit-end strobe at the end of phase 3; within a bit, clock high only in phases 1 and 2
    wire phaseEnd = tickEnd && (phase_r == 2'd3);
    wire busFree = sclS && sdaS;
    wire sampleNow = tickEnd && (phase_r == 2'd1);
    wire lastByte = (count_r == 8'(NBYTES - 1));
    wire [7:0] addrWr = {EIDL_SLAVE_ADDR, EIDL_WR_BIT};
    wire [7:0] addrRd = {EIDL_SLAVE_ADDR, EIDL_RD_BIT};
    // byte-level sequence: write address, word 0, then read address
    wire [7:0] sendByte = (step_r == 2'd0) ? addrWr :
        (step_r == 2'd1) ? EIDL_START_WORD : addrRd;
    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tick_r <= 16'h0000;
            phase_r <= 2'd0;
        end else if (state_r == IDLE || state_r == FINISH || tickEnd) begin
            tick_r <= 16'h0000;
            phase_r <= (state_r == IDLE) ? 2'd0 : phase_r + 2'd1;
        end else begin
            tick_r <= tick_r + 16'h0001;
        end
    end
    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_r <= IDLE;
            retState_r <= IDLE;
            bit_r <= 4'h0;
            shift_r <= 8'h00;
            step_r <= 2'd0;
            count_r <= 8'h00;
            image_r <= '0;
            sdaLow_r <= 1'b0;
            sclLow_r <= 1'b0;
            ackBad_r <= 1'b0;
            loadDone <= 1'b0;
            eepromFound <= 1'b0;
        end else begin
            unique case (state_r)
                IDLE: begin
                    if (busFree) begin
                        state_r <= START;
                    end
                end
                START: begin
                    // phases 0-1 release, 2 data low, 3 clock low
                    if (tickEnd && phase_r == 2'd1) begin
                        sdaLow_r <= 1'b1;
                    end
                    if (tickEnd && phase_r == 2'd2) begin
                        sclLow_r <= 1'b1;
                    end
                    if (phaseEnd) begin
                        state_r <= SEND;
                        shift_r <= sendByte;
                        sdaLow_r <= ~sendByte[7];
                        bit_r <= 4'h0;
                    end
                end
                SEND: begin
                    sclLow_r <= (phase_r == 2'd0) || (phase_r == 2'd3);
                    if (phaseEnd) begin
                        // next bit goes out while the clock is still low
                        sdaLow_r <= ~shift_r[6];
                        shift_r <= {shift_r[6:0], 1'b0};
                        bit_r <= bit_r + 4'h1;
                        if (bit_r == 4'd7) begin
                            state_r <= RACK;
                            sdaLow_r <= 1'b0;
                        end
                    end
                end
                RACK: begin
                    sclLow_r <= (phase_r == 2'd0) || (phase_r == 2'd3);
                    if (sampleNow) begin
                        ackBad_r <= sdaS;
                    end
                    if (phaseEnd) begin
                        if (ackBad_r) begin
                            state_r <= STOP;
                        end else if (step_r == 2'd2) begin
                            state_r <= READ;
                            eepromFound <= 1'b1;
                            bit_r <= 4'h0;
                        end else if (step_r == 2'd1) begin
                            state_r <= REPSTART;
                            step_r <= 2'd2;
                        end else begin
                            state_r <= SEND;
                            step_r <= 2'd1;
                            shift_r <= EIDL_START_WORD;
                            sdaLow_r <= ~EIDL_START_WORD[7];
                            bit_r <= 4'h0;
                        end
                    end
                end
                REPSTART: begin
                    // release data while low, raise clock, then start again
                    sdaLow_r <= 1'b0;
                    sclLow_r <= (phase_r == 2'd0);
                    if (phaseEnd) begin
                        state_r <= START;
                    end
                end
                READ: begin
                    sdaLow_r <= 1'b0;
                    sclLow_r <= (phase_r == 2'd0) || (phase_r == 2'd3);
                    if (sampleNow) begin
                        shift_r <= {shift_r[6:0], sdaS};
                    end
                    if (phaseEnd) begin
                        bit_r <= bit_r + 4'h1;
                        if (bit_r == 4'd7) begin
                            image_r[count_r*8 +: 8] <= shift_r;
                            state_r <= MACK;
                        end
                    end
                end
                MACK: begin
                    // ack every byte but the last, which gets a not-ack
                    sdaLow_r <= ~lastByte;
                    sclLow_r <= (phase_r == 2'd0) || (phase_r == 2'd3);
                    if (phaseEnd) begin
                        sdaLow_r <= 1'b0;
                        bit_r <= 4'h0;
                        count_r <= count_r + 8'h01;
                        state_r <= lastByte ? STOP : READ;
                    end
                end
                STOP: begin
                    // data held low under clock, clock up, then data up
                    if (phase_r == 2'd0) begin
                        sdaLow_r <= 1'b1;
                        sclLow_r <= 1'b1;
                    end
                    if (phase_r == 2'd1) begin
                        sclLow_r <= 1'b0;
                    end
                    if (tickEnd && phase_r == 2'd2) begin
                        sdaLow_r <= 1'b0;
                    end
                    if (phaseEnd) begin
                        state_r <= FINISH;
                    end
                end
                FINISH: begin
                    loadDone <= 1'b1;
                end
                default: state_r <= IDLE;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////
    // open-drain: enable low drives a zero, high releases
    // one cycle of pin lag, equal on both lines, keeps outputs on flops
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
            sclOe <= 1'b1;
            sdaOe <= 1'b1;
        end else begin
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
            sclOe <= ~sclLow_r;
            sdaOe <= ~sdaLow_r;
        end
    end
    ////////////////////////////////////////////////////////////////
    // identifiers fall back to defaults when nothing answered
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            vendorIdent <= EIDL_DEF_VENDOR;
            deviceIdent <= EIDL_DEF_DEVICE;
            subsys_vendor_ident <= EIDL_DEF_SSVEN;
            subsys_device_ident <= EIDL_DEF_SSDEV;
            configBits <= '0;
        end else if (state_r == FINISH && !loadDone && eepromFound) begin
            vendorIdent <= image_r[EIDL_POS_VENDOR +: 16];
            deviceIdent <= image_r[EIDL_POS_DEVICE +: 16];
            subsys_vendor_ident <= image_r[EIDL_POS_SSVEN +: 16];
            subsys_device_ident <= image_r[EIDL_POS_SSDEV +: 16];
            configBits <= image_r[8*NBYTES-1:64];
        end else if (state_r == FINISH && !loadDone) begin
            vendorIdent <= EIDL_DEF_VENDOR;
            deviceIdent <= EIDL_DEF_DEVICE;
            subsys_vendor_ident <= EIDL_DEF_SSVEN;
            subsys_device_ident <= EIDL_DEF_SSDEV;
        end
    end
endmodule

// ### eidl_monitor.sv
// checker for the identification loader pins and outputs
`timescale 1ns/1ps
module eidl_monitor
    import eidl_pkg::*;
#(
    parameter int NBYTES = EIDL_NBYTES,
    parameter int QTR = EIDL_QTR_CYC
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic sclIn,
    input wire logic sclOut,
    input wire logic sclOe,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic [15:0] vendorIdent,
    input wire logic [15:0] deviceIdent,
    input wire logic [15:0] subsys_vendor_ident,
    input wire logic [15:0] subsys_device_ident,
    input wire logic [8*NBYTES-1:64] configBits,
    input wire logic loadDone,
    input wire logic eepromFound
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    sequence startCond; $fell(sdaOe) && sclOe; endsequence
    sequence busFree; $past(sclIn) && $past(sdaIn); endsequence
    AST_OPEN_DRAIN: assert property (!sclOut && !sdaOut)
        else $error("pin value not low");
    AST_START_FREE: assert property (startCond |-> busFree)
        else $error("start on busy bus");
    AST_START_LOW: assert property (startCond |=> !sdaOe [*2])
        else $error("start not held");
    AST_HOLD_RISE: assert property ($rose(sclOe) |-> $stable(sdaOe))
        else $error("data moved at clock rise");
    AST_HOLD_FALL: assert property ($fell(sclOe) |-> $stable(sdaOe))
        else $error("data moved at clock fall");
    AST_STOP_IDLE: assert property (loadDone |-> sclOe && sdaOe)
        else $error("bus not released after stop");
    AST_DONE_HOLD: assert property (loadDone |=> loadDone
        && $stable(vendorIdent) && $stable(configBits))
        else $error("result changed after load");
    AST_DEFAULTS: assert property (!(loadDone && eepromFound) |->
        vendorIdent == EIDL_DEF_VENDOR && deviceIdent == EIDL_DEF_DEVICE
        && subsys_vendor_ident == EIDL_DEF_SSVEN
        && subsys_device_ident == EIDL_DEF_SSDEV)
        else $error("defaults not shown");
endmodule
bind eidl_loader eidl_monitor #(.NBYTES(NBYTES), .QTR(QTR)) mon (
    .clock(clock),
    .resetn(resetn),
    .sclIn(sclIn),
    .sclOut(sclOut),
    .sclOe(sclOe),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .vendorIdent(vendorIdent),
    .deviceIdent(deviceIdent),
    .subsys_vendor_ident(subsys_vendor_ident),
    .subsys_device_ident(subsys_device_ident),
    .configBits(configBits),
    .loadDone(loadDone),
    .eepromFound(eepromFound)
);

// ### eidl_eeprom.sv
// behavioural two-wire eeprom at the loader far side
`timescale 1ns/1ps
module eidl_eeprom (
    input wire logic scl,
    input wire logic sda,
    input wire logic present,
    output logic sdaOe
);
    logic [7:0] mem [0:255];
    logic [7:0] sh, ptr;
    logic act = 0, hdr = 0, rd = 0;
    int bits;
    initial sdaOe = 1;
    // power loss releases the line, else a cut transfer hangs the bus
    always @(negedge present) sdaOe = 1;
    always @(negedge sda) if (scl && present) begin
        bits = 0;
        hdr = 1;
        act = 1;
    end
    always @(posedge sda) if (scl) act = 0;
    always @(posedge scl) if (act) begin
        sh = {sh[6:0], sda};
        bits++;
    end
    always @(negedge scl) if (act) begin
        if (bits == 8 && hdr) begin
            hdr = 0;
            rd = sh[0];
            act = (sh[7:1] == 7'h50);
            sdaOe = !act;
        end else if (bits == 8) begin
            if (!rd) ptr = sh;
            else ptr++;
            sdaOe = rd;
        end else if (bits == 9) begin
            bits = 0;
            sdaOe = !(rd && !sh[0]) || mem[ptr][7];
            if (rd && sh[0]) act = 0;
        end else if (rd && !hdr) begin
            sdaOe = mem[ptr][7-bits];
        end
    end
endmodule

// ### tb_eidl_loader.sv
// self-checking bench for the identification loader
`timescale 1ns/1ps
module tb_eidl_loader;
    import eidl_pkg::*;
    localparam int NB = 10;
    logic clock = 0, resetn = 0, present = 0, busHold = 0;
    logic sclOe, sdaOe, epOe, loadDone, found;
    logic [15:0] ven, dev, ssv, ssd;
    logic [8*NB-1:64] cfg;
    logic [80:0] expQ[$];
    logic [80:0] e;
    int failures = 0, n_checks = 0;
    wire logic scl = sclOe;
    wire logic sda = sdaOe & epOe & !busHold;
    always #5 clock = ~clock;
    eidl_loader #(.NBYTES(NB), .QTR(4)) DUT (.clock(clock), .resetn(resetn),
        .sclIn(scl), .sclOut(), .sclOe(sclOe), .sdaIn(sda), .sdaOut(),
        .sdaOe(sdaOe), .vendorIdent(ven), .deviceIdent(dev),
        .subsys_vendor_ident(ssv), .subsys_device_ident(ssd),
        .configBits(cfg), .loadDone(loadDone), .eepromFound(found));
    eidl_eeprom EP (.scl(scl), .sda(sda), .present(present), .sdaOe(epOe));
    ////////////////////////////////////////
    task automatic check(string nm, logic [63:0] seen, logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge loadDone) begin
        #1;
        e = expQ.size() ? expQ.pop_front() : '1;
        check("vendor", ven, e[15:0]);
        check("device", dev, e[31:16]);
        check("ssvendor", ssv, e[47:32]);
        check("ssdevice", ssd, e[63:48]);
        check("found", found, e[80]);
        if (e[80]) check("config", cfg, e[79:64]);
    end
    // busy counts cycles of a held data line, abortAt cuts the load short
    task automatic run(logic pres, int busy, int abortAt);
        int i;
        present = 0;
        resetn = 0;
        repeat (2) @(negedge clock);
        present = pres;
        busHold = (busy > 0);
        resetn = 1;
        for (i = 0; i < busy; i++) begin
            @(negedge clock);
            check("idle", sclOe, 1);
            check("idlesda", sdaOe, 1);
        end
        busHold = 0;
        if (abortAt > 0) begin
            repeat (abortAt) @(negedge clock);
            return;
        end
        e = {pres, 80'h0};
        for (i = 0; i < NB; i++) e[8*i +: 8] = EP.mem[i];
        if (!pres) e[63:0] = {EIDL_DEF_SSDEV, EIDL_DEF_SSVEN,
            EIDL_DEF_DEVICE, EIDL_DEF_VENDOR};
        expQ.push_back(e);
        for (i = 0; i < 4000 && loadDone !== 1'b1; i++) @(negedge clock);
        if (loadDone !== 1'b1) begin
            failures++;
            tally_and_finish();
        end
        repeat (60) @(negedge clock);
        check("restart", {sclOe, sdaOe}, 2'h3);
    endtask
    initial begin
        void'($urandom(63));
        for (int t = 0; t < 5; t++) begin
            for (int i = 0; i < 256; i++) EP.mem[i] = 8'($urandom);
            run(t != 1, t == 2 ? 30 : 0, t == 3 ? 700 : 0);
            $display("test %0d done", t);
        end
        tally_and_finish();
    end
endmodule
